// >>> csits_defines.svh
// constants shared by the serial channel end and the link master end
// assumes inclusion by bare name ahead of the package and both ends
`ifndef CSITS_DEFINES_SVH
`define CSITS_DEFINES_SVH
// ----------------------------------------------------------------
// channel end register offsets
// ----------------------------------------------------------------
`define CSITS_A_DATA 8'h00
`define CSITS_A_STAT 8'h04
`define CSITS_A_FCLR 8'h08
`define CSITS_A_MODE 8'h0C
`define CSITS_A_START 8'h10
`define CSITS_A_STOP 8'h14
`define CSITS_A_OUTEN 8'h18
// ----------------------------------------------------------------
// master end register offsets
// ----------------------------------------------------------------
`define CSITS_M_DATA 8'h00
`define CSITS_M_CFG 8'h04
`define CSITS_M_DIV 8'h08
`define CSITS_M_STAT 8'h0C
// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define CSITS_B_SRC 0
`define CSITS_B_DAP 1
`define CSITS_B_CKP 2
`define CSITS_B_LSB 3
`define CSITS_B_LEN8 4
`define CSITS_F_MODE 4:0
`define CSITS_F_PS0 11:8
`define CSITS_F_PS1 15:12
`define CSITS_B_CKS 16
`define CSITS_F_CFG 16:0
`define CSITS_F_DIV 7:1
`define CSITS_F_BYTE 7:0
`define CSITS_B_OVF 0
`define CSITS_B_BFF 5
`define CSITS_B_BSY 6
`define CSITS_B_CH0 0
`define CSITS_P_SCK 1
`define CSITS_P_SI 0
// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define CSITS_MODE_RST 5'h10
`define CSITS_CFG_RST 17'h00010
`define CSITS_IDLE 1'b1
`define CSITS_LEN7 4'h7
`define CSITS_LEN8 4'h8
`define CSITS_HALF_MIN 4'h8
`endif

// >>> csits_pkg.sv
// types and bit helpers shared by both ends of the serial link
// assumes the defines header is available by bare name
package csits_pkg;
   typedef logic [31:0] csits_word_type;
   typedef logic [7:0] csits_addr_type;
   typedef logic [7:0] csits_byte_type;
   typedef enum logic [1:0] {
      CSITS_IDLE_ST = 2'b00,
      CSITS_PRE_ST = 2'b01,
      CSITS_RUN_ST = 2'b10
   } csits_mst_state_type;

   // bit currently on the wire for a shift register
   function automatic logic csits_cur_bit(csits_byte_type sh, logic lsb, logic len8);
      return lsb ? sh[0] : (len8 ? sh[7] : sh[6]);
   endfunction

   // advance the transmit shifter by one bit
   function automatic csits_byte_type csits_shift_tx(csits_byte_type sh, logic lsb);
      return lsb ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
   endfunction

   // take one received bit into the shifter
   function automatic csits_byte_type csits_shift_rx(csits_byte_type sh, logic b, logic lsb);
      return lsb ? {b, sh[7:1]} : {sh[6:0], b};
   endfunction

   // right-align a finished frame, unused top bit reads zero
   function automatic csits_byte_type csits_align_rx(csits_byte_type sh, logic lsb, logic len8);
      if (len8) begin
         return sh;
      end
      return lsb ? {1'b0, sh[7:1]} : {1'b0, sh[6:0]};
   endfunction
endpackage

// >>> csits_link_if.sv
// three-wire serial link between the master end and the channel end
// assumes both ends run on the same core clock
`timescale 1ns/1ns
`default_nettype none
interface csits_link_if;
   logic serial_clock_pin; // clock, driven by the master
   logic serial_in_pin; // data from master to channel
   logic serial_out_pin; // data from channel to master
   modport dev_mp (input serial_clock_pin, input serial_in_pin, output serial_out_pin);
   modport mst_mp (output serial_clock_pin, output serial_in_pin, input serial_out_pin);
endinterface
`default_nettype wire

// >>> csits_sync.sv
// two flip-flop synchroniser for pins from outside the clock domain
// assumes the inputs change no faster than the core clock can follow
`timescale 1ns/1ns
`default_nettype none
module csits_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '1
) (
   input wire logic clk_i, // core clock
   input wire logic rstn_i, // async reset, active low
   input wire logic [W-1:0] d_i, // asynchronous inputs
   output logic [W-1:0] q_o // synchronised outputs
);
   logic [W-1:0] meta_r;

   // first stage feeds only the second stage
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_r <= INIT;
         q_o <= INIT;
      end else begin
         meta_r <= d_i;
         q_o <= meta_r;
      end
   end
endmodule
`default_nettype wire

// >>> csits_slave.sv
// channel end: slave transmit/receive over a master-driven clock
// assumes an apb master on the core clock and a master on the link
`timescale 1ns/1ns
`default_nettype none
`include "csits_defines.svh"
module csits_slave (
   input wire logic CORE_CLK_I, // core clock, 20 MHz
   input wire logic RSTN_I, // async reset, active low
   input wire logic PSEL_I, // apb select
   input wire logic PENABLE_I, // apb access phase
   input wire logic PWRITE_I, // apb direction, 1 is write
   input wire csits_pkg::csits_addr_type PADDR_I, // apb byte address
   input wire csits_pkg::csits_word_type PWDATA_I, // apb write data
   output var csits_pkg::csits_word_type PRDATA_O, // apb read data
   output logic PREADY_O, // apb ready
   output logic CHANNEL_IRQ_O, // channel interrupt, one-cycle pulse
   csits_link_if.dev_mp LINK // serial link pins
);
   import csits_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [4:0] mode_r;
   logic [7:0] outen_r;
   logic en_r, busy_r, tx_full_r, rx_full_r, ovf_r, k_prev_r;
   csits_byte_type tx_buf_r, tx_cur_r, tx_sh_r, rx_buf_r, rx_sh_r, rx_nxt;
   logic [3:0] cnt_r;
   logic [1:0] pins_s;
   logic k, lead, trail, dap, lsb, len8, smp, shf, start, take, done;
   logic acc, wr, rd, rdback, w_data, w_fclr, w_mode, w_start, w_stop, w_outen, r_data;
   csits_word_type rd_mux;

   // ----------------------------------------------------------------
   // pin sampling and edge detection
   // ----------------------------------------------------------------
   // clock and data are both resampled so they keep their relative timing
   csits_sync #(.W(2), .INIT(2'b11)) u_sync (
      .clk_i(CORE_CLK_I),
      .rstn_i(RSTN_I),
      .d_i({LINK.serial_clock_pin, LINK.serial_in_pin}),
      .q_o(pins_s)
   );

   assign dap = mode_r[`CSITS_B_DAP];
   assign lsb = mode_r[`CSITS_B_LSB];
   assign len8 = mode_r[`CSITS_B_LEN8];
   // the pin clock is used undivided, only optionally inverted
   assign k = pins_s[`CSITS_P_SCK] ^ mode_r[`CSITS_B_CKP];
   // a half period under one core cycle can hide an edge
   assign lead = k_prev_r & ~k;
   assign trail = ~k_prev_r & k;
   assign smp = dap ? lead : trail;
   assign shf = dap ? trail : lead;
   assign start = lead & ~busy_r & en_r;
   assign take = busy_r ? smp : (start & dap);
   assign done = take & (cnt_r == ((len8 ? `CSITS_LEN8 : `CSITS_LEN7) - 4'h1));
   assign rx_nxt = csits_shift_rx(rx_sh_r, pins_s[`CSITS_P_SI], lsb);

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   assign acc = PSEL_I & PENABLE_I & PREADY_O;
   assign wr = acc & PWRITE_I;
   assign rd = acc & ~PWRITE_I;
   assign w_data = wr & (PADDR_I == `CSITS_A_DATA);
   assign w_fclr = wr & (PADDR_I == `CSITS_A_FCLR);
   assign w_mode = wr & (PADDR_I == `CSITS_A_MODE);
   assign w_start = wr & (PADDR_I == `CSITS_A_START) & PWDATA_I[`CSITS_B_CH0];
   assign w_stop = wr & (PADDR_I == `CSITS_A_STOP) & PWDATA_I[`CSITS_B_CH0];
   assign w_outen = wr & (PADDR_I == `CSITS_A_OUTEN);
   assign r_data = rd & (PADDR_I == `CSITS_A_DATA);
   // in continuous mode a read during a frame shows the word being sent
   assign rdback = busy_r & mode_r[`CSITS_B_SRC];

   // read mux, unmapped addresses read zero
   always_comb begin
      rd_mux = '0;
      case (PADDR_I)
         `CSITS_A_DATA: rd_mux[`CSITS_F_BYTE] = rdback ? tx_cur_r : rx_buf_r;
         `CSITS_A_STAT: begin
            rd_mux[`CSITS_B_OVF] = ovf_r;
            rd_mux[`CSITS_B_BFF] = tx_full_r | rx_full_r;
            rd_mux[`CSITS_B_BSY] = busy_r;
         end
         `CSITS_A_MODE: rd_mux[`CSITS_F_MODE] = mode_r;
         `CSITS_A_START: rd_mux[`CSITS_B_CH0] = en_r;
         `CSITS_A_OUTEN: rd_mux[`CSITS_F_BYTE] = outen_r;
         default: rd_mux = '0;
      endcase
   end

   // ready one cycle into the access phase, read data captured with it
   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         PREADY_O <= 1'b0;
         PRDATA_O <= '0;
      end else begin
         PREADY_O <= PSEL_I & PENABLE_I & ~PREADY_O;
         if (PSEL_I & PENABLE_I & ~PREADY_O) begin
            PRDATA_O <= rd_mux;
         end
      end
   end

   // ----------------------------------------------------------------
   // configuration
   // ----------------------------------------------------------------
   // the interrupt source may change at any time, it takes effect at once
   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         mode_r <= `CSITS_MODE_RST;
         outen_r <= 8'h00;
      end else begin
         if (w_mode) begin
            mode_r <= PWDATA_I[`CSITS_F_MODE];
         end
         if (w_outen) begin
            outen_r <= PWDATA_I[`CSITS_F_BYTE];
         end
      end
   end

   // start sets the enable, stop clears it and drops a frame in flight
   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         en_r <= 1'b0;
      end else if (w_stop) begin
         en_r <= 1'b0;
      end else if (w_start) begin
         en_r <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // shifting
   // ----------------------------------------------------------------
   // the word in the buffer is sent as is, software must have loaded it
   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         k_prev_r <= `CSITS_IDLE;
         busy_r <= 1'b0;
         cnt_r <= 4'h0;
         tx_sh_r <= 8'h00;
         tx_cur_r <= 8'h00;
         rx_sh_r <= 8'h00;
      end else begin
         k_prev_r <= k;
         if (start) begin
            busy_r <= 1'b1;
            tx_sh_r <= tx_buf_r;
            tx_cur_r <= tx_buf_r;
            cnt_r <= 4'h0;
         end else if (busy_r & shf) begin
            tx_sh_r <= csits_shift_tx(tx_sh_r, lsb);
         end
         if (take) begin
            rx_sh_r <= rx_nxt;
            cnt_r <= done ? 4'h0 : 4'(cnt_r + 4'h1);
         end
         if (done | w_stop) begin
            busy_r <= 1'b0;
         end
         if (w_stop) begin
            cnt_r <= 4'h0;
         end
      end
   end

   // transmit buffer: a write while full overwrites the pending word
   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         tx_buf_r <= 8'h00;
         tx_full_r <= 1'b0;
      end else if (w_data) begin
         tx_buf_r <= PWDATA_I[`CSITS_F_BYTE];
         tx_full_r <= 1'b1;
      end else if (start) begin
         tx_full_r <= 1'b0;
      end
   end

   // receive buffer: a finished frame wins over a read in the same cycle
   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         rx_buf_r <= 8'h00;
         rx_full_r <= 1'b0;
      end else if (done) begin
         rx_buf_r <= csits_align_rx(rx_nxt, lsb, len8);
         rx_full_r <= 1'b1;
      end else if (r_data & ~rdback) begin
         rx_full_r <= 1'b0;
      end
   end

   // overrun: only error kept; set beats a clear in the same cycle
   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         ovf_r <= 1'b0;
      end else if (done & rx_full_r) begin
         ovf_r <= 1'b1;
      end else if (w_fclr & PWDATA_I[`CSITS_B_OVF]) begin
         ovf_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // single mode fires at frame end, continuous when the buffer empties
   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         CHANNEL_IRQ_O <= 1'b0;
      end else begin
         CHANNEL_IRQ_O <= mode_r[`CSITS_B_SRC] ? start : done;
      end
   end

   // with data phase 1 the first bit waits on the pin before the clock
   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         LINK.serial_out_pin <= `CSITS_IDLE;
      end else if (!outen_r[`CSITS_B_CH0]) begin
         LINK.serial_out_pin <= `CSITS_IDLE;
      end else if (busy_r) begin
         LINK.serial_out_pin <= csits_cur_bit(tx_sh_r, lsb, len8);
      end else if (dap) begin
         LINK.serial_out_pin <= csits_cur_bit(tx_buf_r, lsb, len8);
      end else begin
         LINK.serial_out_pin <= `CSITS_IDLE;
      end
   end
endmodule
`default_nettype wire

// >>> csits_master.sv
// master end: makes the serial clock and exchanges one word per order
// assumes an apb master on the core clock and the channel on the link
`timescale 1ns/1ns
`default_nettype none
`include "csits_defines.svh"
module csits_master (
   input wire logic CORE_CLK_I, // core clock, 20 MHz
   input wire logic RSTN_I, // async reset, active low
   input wire logic PSEL_I, // apb select
   input wire logic PENABLE_I, // apb access phase
   input wire logic PWRITE_I, // apb direction, 1 is write
   input wire csits_pkg::csits_addr_type PADDR_I, // apb byte address
   input wire csits_pkg::csits_word_type PWDATA_I, // apb write data
   output var csits_pkg::csits_word_type PRDATA_O, // apb read data
   output logic PREADY_O, // apb ready
   csits_link_if.mst_mp LINK // serial link pins
);
   import csits_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   csits_mst_state_type state_r;
   logic [16:0] cfg_r;
   logic [6:0] div_r, hc_r;
   logic [15:0] pc_r, mask;
   logic [3:0] ps, cnt_r, cyc_r, cnt_nx, len;
   logic due_r, miso_s, tick, half, ld, smp, lsb, len8, acc, go;
   csits_byte_type tx_sh_r, rx_sh_r, rx_r, nb;
   csits_word_type rd_mux;

   csits_sync #(.W(1), .INIT(1'b1)) u_sync (
      .clk_i(CORE_CLK_I),
      .rstn_i(RSTN_I),
      .d_i(LINK.serial_out_pin),
      .q_o(miso_s)
   );

   // ----------------------------------------------------------------
   // clock generation
   // ----------------------------------------------------------------
   assign lsb = cfg_r[`CSITS_B_LSB];
   assign len8 = cfg_r[`CSITS_B_LEN8];
   assign len = len8 ? `CSITS_LEN8 : `CSITS_LEN7;
   assign ps = cfg_r[`CSITS_B_CKS] ? cfg_r[`CSITS_F_PS1] : cfg_r[`CSITS_F_PS0];
   assign mask = 16'((16'h0001 << ps) - 16'h0001);
   assign tick = (pc_r & mask) == mask;
   // floor on the half period keeps the clock far below core clock / 6
   assign half = due_r & (cyc_r == (`CSITS_HALF_MIN - 4'h1));
   assign ld = LINK.serial_clock_pin ^ cfg_r[`CSITS_B_CKP]; // next edge is leading
   assign smp = cfg_r[`CSITS_B_DAP] ? ld : ~ld;
   assign cnt_nx = smp ? 4'(cnt_r + 4'h1) : cnt_r;
   assign nb = csits_shift_tx(tx_sh_r, lsb);
   assign acc = PSEL_I & PENABLE_I & PREADY_O;
   assign go = acc & PWRITE_I & (PADDR_I == `CSITS_M_DATA) & (state_r == CSITS_IDLE_ST);

   // half period is the longer of divider+1 ticks of the operation clock and eight core cycles
   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         pc_r <= 16'h0000;
         hc_r <= 7'h00;
         due_r <= 1'b0;
         cyc_r <= 4'h0;
      end else begin
         pc_r <= 16'(pc_r + 16'h0001);
         if (cyc_r != (`CSITS_HALF_MIN - 4'h1)) begin
            cyc_r <= 4'(cyc_r + 4'h1);
         end
         if (tick & (hc_r == div_r)) begin
            hc_r <= 7'h00;
            due_r <= 1'b1;
         end else if (tick) begin
            hc_r <= 7'(hc_r + 7'h01);
         end
         if (half | go) begin
            due_r <= 1'b0;
            cyc_r <= 4'h0;
         end
         if (go) begin
            hc_r <= 7'h00;
         end
      end
   end

   // ----------------------------------------------------------------
   // frame sequencer
   // ----------------------------------------------------------------
   // one setup half period, then 2*len edges, ending on an idle clock
   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         state_r <= CSITS_IDLE_ST;
         LINK.serial_clock_pin <= `CSITS_IDLE;
         LINK.serial_in_pin <= `CSITS_IDLE;
         tx_sh_r <= 8'h00;
         rx_sh_r <= 8'h00;
         rx_r <= 8'h00;
         cnt_r <= 4'h0;
      end else begin
         case (state_r)
            CSITS_IDLE_ST: begin
               LINK.serial_clock_pin <= `CSITS_IDLE ^ cfg_r[`CSITS_B_CKP];
               if (go) begin
                  state_r <= CSITS_PRE_ST;
                  tx_sh_r <= PWDATA_I[`CSITS_F_BYTE];
                  LINK.serial_in_pin <= csits_cur_bit(PWDATA_I[`CSITS_F_BYTE], lsb, len8);
                  cnt_r <= 4'h0;
               end
            end
            CSITS_PRE_ST: begin
               if (half) begin
                  state_r <= CSITS_RUN_ST;
               end
            end
            CSITS_RUN_ST: begin
               if (half) begin
                  LINK.serial_clock_pin <= ~LINK.serial_clock_pin;
                  cnt_r <= cnt_nx;
                  if (smp) begin
                     rx_sh_r <= csits_shift_rx(rx_sh_r, miso_s, lsb);
                  end else if (cnt_r != 4'h0) begin
                     tx_sh_r <= nb;
                     LINK.serial_in_pin <= csits_cur_bit(nb, lsb, len8);
                  end
                  if (~ld & (cnt_nx == len)) begin
                     state_r <= CSITS_IDLE_ST;
                     rx_r <= csits_align_rx(smp ? csits_shift_rx(rx_sh_r, miso_s, lsb)
                                                : rx_sh_r, lsb, len8);
                  end
               end
            end
            default: state_r <= CSITS_IDLE_ST;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // registers and apb
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         cfg_r <= `CSITS_CFG_RST;
         div_r <= 7'h00;
      end else if (acc & PWRITE_I & (PADDR_I == `CSITS_M_CFG)) begin
         cfg_r <= PWDATA_I[`CSITS_F_CFG];
      end else if (acc & PWRITE_I & (PADDR_I == `CSITS_M_DIV)) begin
         div_r <= PWDATA_I[`CSITS_F_DIV];
      end
   end

   always_comb begin
      rd_mux = '0;
      case (PADDR_I)
         `CSITS_M_DATA: rd_mux[`CSITS_F_BYTE] = rx_r;
         `CSITS_M_CFG: rd_mux[`CSITS_F_CFG] = cfg_r;
         `CSITS_M_DIV: rd_mux[`CSITS_F_DIV] = div_r;
         `CSITS_M_STAT: rd_mux[`CSITS_B_BSY] = state_r != CSITS_IDLE_ST;
         default: rd_mux = '0;
      endcase
   end

   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         PREADY_O <= 1'b0;
         PRDATA_O <= '0;
      end else begin
         PREADY_O <= PSEL_I & PENABLE_I & ~PREADY_O;
         if (PSEL_I & PENABLE_I & ~PREADY_O) begin
            PRDATA_O <= rd_mux;
         end
      end
   end
endmodule
`default_nettype wire

// >>> csits_link_properties.sv
// link checker: timing and framing seen on the three serial pins
// assumes it watches the interface joining the master and channel ends
`timescale 1ns/1ns
`default_nettype none
module csits_link_properties (
   input wire logic CORE_CLK_I, // core clock
   input wire logic RSTN_I, // async reset, active low
   input wire logic serial_clock_pin, // link clock
   input wire logic serial_in_pin, // master to channel data
   input wire logic serial_out_pin // channel to master data
);
   // ----------------------------------------------------------------
   // burst edge count
   // ----------------------------------------------------------------
   logic [3:0] quiet_r;
   logic [4:0] edges_r;
   // a burst ends after ten quiet cycles, longer than the eight-cycle half period at divider and prescaler 0
   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         quiet_r <= 4'h0;
         edges_r <= 5'h00;
      end else if ($changed(serial_clock_pin)) begin
         quiet_r <= 4'h0;
         edges_r <= edges_r + 5'h01;
      end else if (quiet_r != 4'hA) begin
         quiet_r <= quiet_r + 4'h1;
      end else begin
         edges_r <= 5'h00;
      end
   end
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RSTN_I);
   a_half_period_min: assert property (
      $changed(serial_clock_pin) |=> $stable(serial_clock_pin)[*7])
      else $error("link clock half period too short");
   a_out_sync_lag: assert property (
      $changed(serial_clock_pin) |=> $stable(serial_out_pin)[*2])
      else $error("channel output moved before synchroniser delay");
   a_out_bit_hold: assert property (
      $changed(serial_out_pin) |=> $stable(serial_out_pin)[*3])
      else $error("channel output bit not held");
   a_in_bit_hold: assert property (
      $changed(serial_in_pin) |=> $stable(serial_in_pin)[*3])
      else $error("master data bit not held");
   // master data moves only with a clock edge or in setup, a full half period ahead
   a_in_data_setup: assert property (
      $changed(serial_in_pin) |=> $stable(serial_clock_pin)[*7])
      else $error("master data moved too close to a clock edge");
   // one toggle is a polarity change at idle, 14 or 16 are whole frames
   a_frame_edges: assert property (
      quiet_r == 4'hA |-> edges_r inside {5'h00, 5'h01, 5'h0E, 5'h10})
      else $error("link clock burst has wrong edge count");
endmodule
`default_nettype wire

// >>> tb.sv
// bench: channel end and master end joined, apb orders to each end
// assumes the design files and the link checker are compiled first
`timescale 1ns/1ns
`default_nettype none
`include "csits_defines.svh"
module tb;
   import csits_pkg::*;
   logic CORE_CLK_I = 1'b0;
   logic RSTN_I = 1'b0;
   logic [1:0] psel = 2'b00;
   logic [1:0] rdy;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic irq;
   csits_addr_type pa = 8'h00;
   csits_word_type pw = 32'h0;
   csits_word_type prd [2];
   csits_word_type rd;
   int irqs = 0;
   int mismatches = 0;
   int check_count = 0;
   // rows: channel mode, master byte, channel byte
   logic [20:0] rows [8] = '{21'h10A53C, 21'h12817E, 21'h145AC3, 21'h180180,
      21'h1EF00F, 21'h00552A, 21'h0AFF40, 21'h169669};
   csits_link_if csits_link_if_i ();
   csits_slave csits_slave_i (.CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I), .PSEL_I(psel[0]),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pw), .PRDATA_O(prd[0]),
      .PREADY_O(rdy[0]), .CHANNEL_IRQ_O(irq), .LINK(csits_link_if_i.dev_mp));
   csits_master csits_master_i (.CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I), .PSEL_I(psel[1]),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pw), .PRDATA_O(prd[1]),
      .PREADY_O(rdy[1]), .LINK(csits_link_if_i.mst_mp));
   csits_link_properties csits_link_properties_i (.CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I),
      .serial_clock_pin(csits_link_if_i.serial_clock_pin),
      .serial_in_pin(csits_link_if_i.serial_in_pin),
      .serial_out_pin(csits_link_if_i.serial_out_pin));
   // ----------------------------------------------------------------
   // apb master, checks and frames
   // ----------------------------------------------------------------
   // one transfer to end s (0 channel, 1 master); held until ready
   task automatic apb(input int s, input logic w, input csits_addr_type a,
      input csits_word_type d);
      @(posedge CORE_CLK_I);
      psel[s] <= 1'b1;
      pwr <= w;
      pa <= a;
      pw <= d;
      @(posedge CORE_CLK_I);
      pen <= 1'b1;
      // no cycle count assumed: only the watchdog ends a wait that never answers
      do begin
         @(posedge CORE_CLK_I);
      end while (rdy[s] !== 1'b1);
      rd = prd[s];
      psel <= 2'b00;
      pen <= 1'b0;
   endtask
   task automatic chk(input csits_word_type g, input csits_word_type e);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic rc(input int s, input csits_addr_type a, input csits_word_type e);
      apb(s, 1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   // polls master then channel until neither reports busy
   task automatic go(input csits_byte_type m, input csits_byte_type s);
      apb(0, 1'b1, `CSITS_A_DATA, {24'h0, s});
      apb(1, 1'b1, `CSITS_M_DATA, {24'h0, m});
      for (int e = 1; e >= 0; e--) begin
         repeat (60) begin
            apb(e, 1'b0, (e == 1) ? `CSITS_M_STAT : `CSITS_A_STAT, 32'h0);
            if (rd[6] === 1'b0) break;
         end
         chk({31'h0, rd[6]}, 32'h0);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      forever #25 CORE_CLK_I = ~CORE_CLK_I;
   end
   always @(posedge CORE_CLK_I) begin
      if (irq === 1'b1) irqs++;
   end
   // a hang cuts the run short well beyond the expected length
   initial begin
      #1000000;
      mismatches++;
      summarize();
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [4:0] cfg;
      csits_byte_type msk;
      repeat (4) @(posedge CORE_CLK_I);
      RSTN_I <= 1'b1;
      rc(0, `CSITS_A_MODE, 32'h10);
      rc(0, `CSITS_A_OUTEN, 32'h0);
      rc(1, `CSITS_M_CFG, 32'h10);
      rc(0, 8'h1C, 32'h0);
      apb(1, 1'b1, `CSITS_M_DIV, 32'hFF);
      rc(1, `CSITS_M_DIV, 32'hFE);
      apb(1, 1'b1, `CSITS_M_DIV, 32'h0);
      apb(0, 1'b1, `CSITS_A_OUTEN, 32'h1);
      foreach (rows[k]) begin
         cfg = rows[k][20:16];
         msk = cfg[4] ? 8'hFF : 8'h7F;
         apb(0, 1'b1, `CSITS_A_STOP, 32'h1);
         apb(0, 1'b1, `CSITS_A_MODE, {27'h0, cfg});
         apb(1, 1'b1, `CSITS_M_CFG, {27'h0, cfg[4:1], 1'b0});
         repeat (16) @(posedge CORE_CLK_I);
         apb(0, 1'b1, `CSITS_A_START, 32'h1);
         go(rows[k][15:8], rows[k][7:0]);
         rc(0, `CSITS_A_STAT, 32'h20);
         rc(0, `CSITS_A_DATA, {24'h0, rows[k][15:8] & msk});
         rc(0, `CSITS_A_STAT, 32'h0);
         rc(1, `CSITS_M_DATA, {24'h0, rows[k][7:0] & msk});
      end
      chk(irqs, 8);
      go(8'h11, 8'h44);
      apb(0, 1'b1, `CSITS_A_DATA, 32'hAA);
      go(8'h22, 8'h33);
      rc(1, `CSITS_M_DATA, 32'h33);
      rc(0, `CSITS_A_STAT, 32'h21);
      apb(0, 1'b1, `CSITS_A_FCLR, 32'h1);
      rc(0, `CSITS_A_STAT, 32'h20);
      rc(0, `CSITS_A_DATA, 32'h22);
      apb(0, 1'b1, `CSITS_A_MODE, 32'h17);
      apb(0, 1'b1, `CSITS_A_DATA, 32'h5C);
      apb(1, 1'b1, `CSITS_M_DATA, 32'hC5);
      repeat (30) begin
         apb(0, 1'b0, `CSITS_A_STAT, 32'h0);
         if (rd[6] === 1'b1) break;
      end
      chk({31'h0, rd[6]}, 32'h1);
      rc(0, `CSITS_A_DATA, 32'h5C);
      // master still busy: its order is refused, the call only refills the buffer
      go(8'hC5, 8'h5C);
      // second continuous frame, buffer empties at its start
      go(8'hC5, 8'h5C);
      rc(1, `CSITS_M_DATA, 32'h5C);
      chk(irqs, 12);
      RSTN_I <= 1'b0;
      repeat (4) @(posedge CORE_CLK_I);
      RSTN_I <= 1'b1;
      rc(0, `CSITS_A_MODE, 32'h10);
      summarize();
   end
endmodule
`default_nettype wire
